// file: verilog/fdhc_regs.svh
// Register offsets, field positions, reset values and timing figures
`ifndef FDHC_REGS_SVH
`define FDHC_REGS_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define FDHC_A_FUNC 8'h00
`define FDHC_A_CHIP 8'h04
`define FDHC_A_DOR 8'h08
`define FDHC_A_RATE 8'h0C
`define FDHC_A_DSR 8'h10
`define FDHC_A_CONF 8'h14
`define FDHC_A_MODE 8'h18
`define FDHC_A_STAT 8'h1C
`define FDHC_A_ISTAT 8'h20
`define FDHC_A_IEN 8'h24
`define FDHC_A_ICLR 8'h28
// ----------------------------------------
// Field positions
// ----------------------------------------
`define FDHC_B_FDC_EN 3
`define FDHC_B_ALT 2
`define FDHC_B_DMA_EN 3
`define FDHC_B_FIFO 0
`define FDHC_B_M_RD 0
`define FDHC_B_M_WR 1
`define FDHC_B_M_NOBURST 2
`define FDHC_B_M_OD 3
`define FDHC_B_M_DEN 4
`define FDHC_B_M_PERP 6
`define FDHC_B_PC 2
`define FDHC_W_IRQ 2
`define FDHC_E_TC 0
`define FDHC_E_CONF 1
// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define FDHC_R_BYTE 8'h00
`define FDHC_R_RATE 2'h0
`define FDHC_PC_DEFAULT 3'h0
`define FDHC_PC_OFF 3'h7
`define FDHC_PC_LAST 3'h6
// ----------------------------------------
// Timing in picoseconds
// ----------------------------------------
`define FDHC_CLK_PS 4000
`define FDHC_PC_DEF_PS 125000
`define FDHC_PC_1M_PS 41670
`define FDHC_PC_STEP_PS 41670
`define FDHC_PC_MAX_PS 250000
`endif

// file: verilog/fdhc_pkg.sv
// Types shared by the floppy host configuration block
package fdhc_pkg;
   typedef enum logic [1:0] {
      FDHC_DR_500K = 2'h0,
      FDHC_DR_300K = 2'h1,
      FDHC_DR_250K = 2'h2,
      FDHC_DR_1M = 2'h3
   } fdhc_rate_t;
   typedef enum logic [1:0] {
      FDHC_DEN_AUTO = 2'h0,
      FDHC_DEN_AUTO2 = 2'h1,
      FDHC_DEN_OFF = 2'h2,
      FDHC_DEN_ON = 2'h3
   } fdhc_den_t;
   typedef enum {FDHC_ST_IDLE, FDHC_ST_ACC} fdhc_apb_st_t;
endpackage

// file: verilog/fdhc_top.sv
// Floppy controller host configuration, mode and pin polarity logic
`timescale 1ns/1ns
`include "fdhc_regs.svh"

module fdhc_top
   import fdhc_pkg::*;
#(
   parameter int PCW = 7
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic core_irq,
   input wire logic core_drq,
   input wire logic core_high_density,
   input wire logic dack_n,
   input wire logic tc_in,
   output logic irq_out,
   output logic irq_oe,
   output logic drq_out,
   output logic drq_oe,
   output logic density_select_out,
   output logic tc_active,
   output logic fifo_rd_active,
   output logic fifo_wr_active,
   output logic burst_en,
   output logic disk_open_drain,
   output logic perp_active,
   output logic [1:0] data_rate,
   output logic [PCW-1:0] precomp_cycles,
   output logic irq
);
   // ----------------------------------------
   // Register bus
   // ----------------------------------------
   fdhc_apb_st_t st;
   logic acc;
   logic wr;
   logic function_enable_reg_one;
   logic chip_config_one;
   logic digital_output_reg;
   logic [1:0] rate_config_reg;
   logic [2:0] pc_code;
   logic fifo_en;
   logic m_rd;
   logic m_wr;
   logic m_noburst;
   logic next_noburst;
   logic m_od;
   logic [1:0] m_den;
   logic m_perp;
   logic [`FDHC_W_IRQ-1:0] istat;
   logic [`FDHC_W_IRQ-1:0] ien;
   logic [`FDHC_W_IRQ-1:0] ev;
   logic next_en;
   logic next_alt;
   logic next_dma;
   logic [1:0] next_rate;
   logic [2:0] next_pc;
   logic next_fifo;
   logic next_rd;
   logic next_wr;
   logic next_od;
   logic [1:0] next_den;
   logic next_perp;
   logic tc_seen;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
      hit = (a == r);
   endfunction

   function automatic logic [PCW-1:0] pc_calc(input logic [2:0] c, input logic [1:0] r);
      int ps;
      ps = 0;
      if (c == `FDHC_PC_DEFAULT) begin
         ps = (r == FDHC_DR_1M) ? `FDHC_PC_1M_PS : `FDHC_PC_DEF_PS;
      end else if (c != `FDHC_PC_OFF) begin
         ps = int'(c) * `FDHC_PC_STEP_PS;
         if (ps > `FDHC_PC_MAX_PS) begin
            ps = `FDHC_PC_MAX_PS;
         end
      end
      pc_calc = PCW'(ps / `FDHC_CLK_PS);
   endfunction

   assign acc = (st == FDHC_ST_ACC) && psel && penable;
   assign wr = acc && pwrite;

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         st <= FDHC_ST_IDLE;
      end else begin
         unique case (st)
            FDHC_ST_IDLE: if (psel && penable) begin
               st <= FDHC_ST_ACC;
            end
            FDHC_ST_ACC: st <= FDHC_ST_IDLE;
         endcase
      end
   end

   // One wait state, so read data and error come from flops
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= (st == FDHC_ST_IDLE) && psel && penable;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
         if ((st == FDHC_ST_IDLE) && psel && penable) begin
            unique case (paddr)
               `FDHC_A_FUNC: prdata[`FDHC_B_FDC_EN] <= function_enable_reg_one;
               `FDHC_A_CHIP: prdata[`FDHC_B_ALT] <= chip_config_one;
               `FDHC_A_DOR: prdata[`FDHC_B_DMA_EN] <= digital_output_reg;
               `FDHC_A_RATE: prdata[1:0] <= rate_config_reg;
               `FDHC_A_DSR: prdata[4:0] <= {pc_code, rate_config_reg};
               `FDHC_A_CONF: prdata[`FDHC_B_FIFO] <= fifo_en;
               `FDHC_A_MODE: prdata[6:0] <= {m_perp, m_den, m_od, m_noburst, m_wr, m_rd};
               `FDHC_A_STAT: prdata[3:0] <= {tc_seen, chip_config_one, fifo_en, function_enable_reg_one};
               `FDHC_A_ISTAT: prdata[`FDHC_W_IRQ-1:0] <= istat;
               `FDHC_A_IEN: prdata[`FDHC_W_IRQ-1:0] <= ien;
               `FDHC_A_ICLR: prdata <= 32'h0000_0000;
               default: pslverr <= 1'b1;
            endcase
         end
      end
   end

   // ----------------------------------------
   // Configuration next values
   // ----------------------------------------
   // Decoded from the bus address, as the pins would be
   always_comb begin
      next_en = function_enable_reg_one;
      next_alt = chip_config_one;
      next_dma = digital_output_reg;
      next_rate = rate_config_reg;
      next_pc = pc_code;
      next_fifo = fifo_en;
      next_rd = m_rd;
      next_wr = m_wr;
      next_noburst = m_noburst;
      next_od = m_od;
      next_den = m_den;
      next_perp = m_perp;
      if (wr && hit(paddr, `FDHC_A_FUNC)) begin
         next_en = pwdata[`FDHC_B_FDC_EN];
      end
      if (wr && hit(paddr, `FDHC_A_CHIP)) begin
         next_alt = pwdata[`FDHC_B_ALT];
      end
      if (wr && hit(paddr, `FDHC_A_DOR)) begin
         next_dma = pwdata[`FDHC_B_DMA_EN];
      end
      if (wr && (hit(paddr, `FDHC_A_RATE) || hit(paddr, `FDHC_A_DSR))) begin
         next_rate = pwdata[1:0];
      end
      if (wr && hit(paddr, `FDHC_A_DSR)) begin
         next_pc = pwdata[`FDHC_B_PC+2:`FDHC_B_PC];
      end
      if (wr && hit(paddr, `FDHC_A_CONF)) begin
         next_fifo = pwdata[`FDHC_B_FIFO];
      end
      if (wr && hit(paddr, `FDHC_A_MODE)) begin
         next_rd = pwdata[`FDHC_B_M_RD];
         next_wr = pwdata[`FDHC_B_M_WR];
         next_noburst = pwdata[`FDHC_B_M_NOBURST];
         next_od = pwdata[`FDHC_B_M_OD];
         next_den = pwdata[`FDHC_B_M_DEN+1:`FDHC_B_M_DEN];
         next_perp = pwdata[`FDHC_B_M_PERP];
      end
   end

   // ----------------------------------------
   // Configuration registers
   // ----------------------------------------
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         function_enable_reg_one <= 1'b0;
         chip_config_one <= 1'b0;
         digital_output_reg <= 1'b0;
         rate_config_reg <= `FDHC_R_RATE;
         pc_code <= `FDHC_PC_DEFAULT;
      end else begin
         function_enable_reg_one <= next_en;
         chip_config_one <= next_alt;
         digital_output_reg <= next_dma;
         rate_config_reg <= next_rate;
         pc_code <= next_pc;
      end
   end

   // FIFO off and push-pull after reset
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         fifo_en <= 1'b0;
         m_rd <= 1'b1;
         m_wr <= 1'b1;
         m_noburst <= 1'b0;
         m_od <= 1'b0;
         m_den <= FDHC_DEN_AUTO;
         m_perp <= 1'b0;
      end else begin
         fifo_en <= next_fifo;
         m_rd <= next_rd;
         m_wr <= next_wr;
         m_noburst <= next_noburst;
         m_od <= next_od;
         m_den <= next_den;
         m_perp <= next_perp;
      end
   end

   // ----------------------------------------
   // Pin and mode outputs
   // ----------------------------------------
   // Driven from next values so a write shows at the same edge as its register
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         irq_out <= 1'b0;
         irq_oe <= 1'b0;
         drq_out <= 1'b0;
         drq_oe <= 1'b0;
         density_select_out <= 1'b0;
      end else begin
         irq_out <= next_en && core_irq;
         drq_out <= next_en && core_drq;
         irq_oe <= next_en && (next_alt || next_dma);
         drq_oe <= next_en && (next_alt || next_dma);
         if (!next_en) begin
            density_select_out <= 1'b0;
         end else begin
            unique case (next_den)
               FDHC_DEN_OFF: density_select_out <= next_alt;
               FDHC_DEN_ON: density_select_out <= !next_alt;
               default: density_select_out <= core_high_density ^ next_alt;
            endcase
         end
      end
   end

   // Polarity fixed per mode; DACK qualifies the count
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         tc_active <= 1'b0;
      end else begin
         tc_active <= next_en && !dack_n && (tc_in ^ next_alt);
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         fifo_rd_active <= 1'b0;
         fifo_wr_active <= 1'b0;
         burst_en <= 1'b0;
         disk_open_drain <= 1'b0;
         perp_active <= 1'b0;
      end else begin
         fifo_rd_active <= next_en && next_fifo && next_rd;
         fifo_wr_active <= next_en && next_fifo && next_wr;
         burst_en <= next_en && next_fifo && !next_noburst;
         disk_open_drain <= next_od;
         perp_active <= next_en && next_perp;
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         data_rate <= `FDHC_R_RATE;
         precomp_cycles <= '0;
      end else begin
         data_rate <= next_rate;
         precomp_cycles <= pc_calc(next_pc, next_rate);
      end
   end

   // ----------------------------------------
   // Interrupt status
   // ----------------------------------------
   always_comb begin
      ev = '0;
      ev[`FDHC_E_TC] = tc_active && !tc_seen;
      ev[`FDHC_E_CONF] = wr && hit(paddr, `FDHC_A_CONF);
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         tc_seen <= 1'b0;
      end else begin
         tc_seen <= tc_active;
      end
   end

   // New event wins over a clear in the same cycle
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         istat <= '0;
         ien <= '0;
         irq <= 1'b0;
      end else begin
         if (wr && hit(paddr, `FDHC_A_ICLR)) begin
            istat <= (istat & ~pwdata[`FDHC_W_IRQ-1:0]) | ev;
         end else begin
            istat <= istat | ev;
         end
         if (wr && hit(paddr, `FDHC_A_IEN)) begin
            ien <= pwdata[`FDHC_W_IRQ-1:0];
         end
         irq <= |(istat & ien);
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);

   sequence s_chip_wr;
      wr && hit(paddr, `FDHC_A_CHIP);
   endsequence

   sequence s_apb_req;
      psel && penable && !pready;
   endsequence

   AST_DISABLED: assert property (!function_enable_reg_one |-> !irq_oe && !drq_oe && !fifo_rd_active)
      else $error("outputs active while disabled");
   AST_FIFO_ON: assert property ($rose(fifo_rd_active) |-> fifo_en && ($past(fifo_en)
      || $past(wr && hit(paddr, `FDHC_A_CONF))))
      else $error("fifo enabled without configure");
   AST_OD_CAUSE: assert property ($rose(disk_open_drain) |-> $past(wr && hit(paddr, `FDHC_A_MODE)))
      else $error("open drain without mode write");
   AST_CONF: assert property (wr && hit(paddr, `FDHC_A_CONF) && pwdata[`FDHC_B_FIFO] && m_rd
      && function_enable_reg_one |=> fifo_rd_active)
      else $error("configure did not start fifo");
   AST_AT_OE: assert property (function_enable_reg_one && !chip_config_one |-> irq_oe == digital_output_reg)
      else $error("dma enable not honoured");
   AST_ALT_OE: assert property (function_enable_reg_one && chip_config_one |-> irq_oe && drq_oe)
      else $error("alt mode outputs not driven");
   AST_TC: assert property (function_enable_reg_one && !dack_n && (tc_in ^ chip_config_one)
      && !wr |=> tc_active)
      else $error("terminal count polarity");
   AST_DEN: assert property (function_enable_reg_one && m_den == FDHC_DEN_AUTO |=> $past(wr) || density_select_out ==
      ($past(core_high_density) ^ chip_config_one))
      else $error("density polarity");
   AST_PC1M: assert property (pc_code == `FDHC_PC_DEFAULT && rate_config_reg == FDHC_DR_1M |->
      precomp_cycles == PCW'(`FDHC_PC_1M_PS / `FDHC_CLK_PS))
      else $error("default precomp at 1M");
   AST_PCOFF: assert property (pc_code == `FDHC_PC_OFF |-> precomp_cycles == '0)
      else $error("precomp not disabled");
   AST_MODE_CHG: assert property (s_chip_wr ##1 function_enable_reg_one |-> chip_config_one ==
      $past(pwdata[`FDHC_B_ALT]) && irq_oe == (chip_config_one || digital_output_reg))
      else $error("mode change not applied");
   AST_APB: assert property (s_apb_req |=> pready ##1 !pready)
      else $error("apb answer timing");
endmodule

// file: bench/fdhc_dma_model.sv
// DMA controller model answering the block's request line
`timescale 1ns/1ns
// ----------------------------------------
// Grants a short burst, marks the last grant with terminal count
// ----------------------------------------
module fdhc_dma_model #(
   parameter int BURST = 4
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic drq,
   input wire logic alt,
   input wire logic [1:0] gap,
   output logic dack_n,
   output logic tc_in
);
   int wait_cnt;
   int done;
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         dack_n <= 1'b1;
         tc_in <= 1'b0;
         wait_cnt <= 0;
         done <= 0;
      end else if (drq && done < BURST && wait_cnt >= int'(gap)) begin
         dack_n <= 1'b0;
         tc_in <= (done == BURST - 1) ? ~alt : alt;
         done <= done + 1;
         wait_cnt <= 0;
      end else begin
         // Slow answers come from gap; terminal count idles deasserted
         dack_n <= 1'b1;
         tc_in <= alt;
         wait_cnt <= drq ? wait_cnt + 1 : 0;
         if (!drq) begin
            done <= 0;
         end
      end
   end
endmodule

// file: bench/tb.sv
// Self-checking bench for the floppy host configuration block
`timescale 1ns/1ns
`include "fdhc_regs.svh"
module tb
   import fdhc_pkg::*;
;
   logic clock, nrst, psel, penable, pwrite, core_irq, core_drq, core_high_density;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic pready, pslverr, dack_n, tc_in, irq_out, irq_oe, drq_out, drq_oe, density_select_out, tc_active;
   logic fifo_rd_active, fifo_wr_active, burst_en, disk_open_drain, perp_active, irq, e, alt, mon, pd, pt;
   logic [1:0] data_rate, gap;
   logic [6:0] precomp_cycles;
   int mismatches, samples_checked, cycles, seed, n;
   // ----------------------------------------
   // Design and far side
   // ----------------------------------------
   fdhc_top #(.PCW(7)) fdhc_top_inst (.clock(clock), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .core_irq(core_irq), .core_drq(core_drq), .core_high_density(core_high_density), .dack_n(dack_n),
      .tc_in(tc_in), .irq_out(irq_out), .irq_oe(irq_oe), .drq_out(drq_out), .drq_oe(drq_oe),
      .density_select_out(density_select_out), .tc_active(tc_active), .fifo_rd_active(fifo_rd_active),
      .fifo_wr_active(fifo_wr_active), .burst_en(burst_en), .disk_open_drain(disk_open_drain),
      .perp_active(perp_active), .data_rate(data_rate), .precomp_cycles(precomp_cycles), .irq(irq));
   fdhc_dma_model fdhc_dma_model_inst (.clock(clock), .nrst(nrst), .drq(drq_out & drq_oe), .alt(alt),
      .gap(gap), .dack_n(dack_n), .tc_in(tc_in));
   always #2 clock = ~clock;
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic complete_run();
      if (mismatches == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      samples_checked++;
      if (got !== ex) begin
         $display("ERROR %s expected %h seen %h", nm, ex, got);
         mismatches++;
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge clock);
   endtask
   // Hang on pready is cut by the cycle ceiling below
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1) begin
         @(posedge clock);
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] ex, input string nm);
      apb(1'b0, a, 32'h0000_0000);
      chk(nm, ex, q);
   endtask
   function automatic logic [6:0] exp_pc(input int code, input int rate);
      int ps;
      if (code == 7) return 7'h00;
      if (code == 0) ps = (rate == 3) ? `FDHC_PC_1M_PS : `FDHC_PC_DEF_PS;
      else ps = code * `FDHC_PC_STEP_PS;
      if (ps > `FDHC_PC_MAX_PS) ps = `FDHC_PC_MAX_PS;
      return 7'(ps / `FDHC_CLK_PS);
   endfunction
   // ----------------------------------------
   // Terminal count monitor and cycle ceiling
   // ----------------------------------------
   always @(posedge clock) begin
      if (mon) chk("tc_active", 32'(~pd & (pt ^ alt)), 32'(tc_active));
      pd <= dack_n;
      pt <= tc_in;
      cycles++;
      if (cycles > 20000) begin
         mismatches++;
         complete_run();
      end
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      seed = 32'h24071ebc;
      {clock, nrst, psel, penable, pwrite, core_irq, core_drq, core_high_density} = 8'h00;
      {paddr, pwdata, q, e, alt, mon, pd, pt, gap} = '0;
      {mismatches, samples_checked, cycles} = '0;
      tick(5);
      chk("fifo_rd_active", 32'h0, 32'(fifo_rd_active));
      chk("disk_open_drain", 32'h0, 32'(disk_open_drain));
      nrst <= 1'b1;
      core_irq <= 1'b1;
      core_high_density <= 1'b1;
      tick(2);
      chk("precomp_cycles", 32'(exp_pc(0, 0)), 32'(precomp_cycles));
      chk("irq_oe", 32'h0, 32'(irq_oe));
      chk("density_select_out", 32'h0, 32'(density_select_out));
      rd(`FDHC_A_STAT, 32'h0000_0000, "status");
      rd(8'h30, 32'h0000_0000, "unmapped");
      chk("pslverr", 32'h1, 32'(e));
      rd(`FDHC_A_ICLR, 32'h0000_0000, "irq_clear");
      apb(1'b1, `FDHC_A_FUNC, 32'h0000_0008);
      rd(`FDHC_A_STAT, 32'h0000_0001, "status");
      // Each drive mode against each DMA enable setting
      for (int m = 0; m < 4; m++) begin
         alt <= m[1];
         apb(1'b1, `FDHC_A_CHIP, {29'h0, m[1], 2'h0});
         apb(1'b1, `FDHC_A_DOR, {28'h0, m[0], 3'h0});
         for (int k = 0; k < 4; k++) begin
            core_irq <= 1'($random(seed));
            core_high_density <= 1'($random(seed));
            tick(2);
            chk("irq_oe", 32'(alt | m[0]), 32'(irq_oe));
            chk("drq_oe", 32'(alt | m[0]), 32'(drq_oe));
            if (alt | m[0]) chk("irq_out", 32'(core_irq), 32'(irq_out));
            chk("density_select_out", 32'(core_high_density ^ alt), 32'(density_select_out));
         end
         for (int d = 2; d < 4; d++) begin
            apb(1'b1, `FDHC_A_MODE, 32'(d * 16 + 3));
            chk("density_select_out", 32'(alt ^ d[0]), 32'(density_select_out));
         end
         apb(1'b1, `FDHC_A_MODE, 32'h0000_0003);
      end
      rd(`FDHC_A_STAT, 32'h0000_0005, "status");
      chk("fifo_rd_active", 32'h0, 32'(fifo_rd_active));
      apb(1'b1, `FDHC_A_CONF, 32'h0000_0001);
      chk("fifo_rd_active", 32'h1, 32'(fifo_rd_active));
      chk("fifo_wr_active", 32'h1, 32'(fifo_wr_active));
      chk("burst_en", 32'h1, 32'(burst_en));
      apb(1'b1, `FDHC_A_MODE, 32'h0000_004E);
      chk("mode_outputs", 32'h0000_000B, {27'h0, fifo_rd_active, fifo_wr_active, burst_en,
         disk_open_drain, perp_active});
      tick(1);
      chk("irq", 32'h0, 32'(irq));
      rd(`FDHC_A_ISTAT, 32'h0000_0002, "irq_status");
      apb(1'b1, `FDHC_A_IEN, 32'h0000_0002);
      tick(1);
      chk("irq", 32'h1, 32'(irq));
      apb(1'b1, `FDHC_A_ICLR, 32'h0000_0002);
      tick(1);
      chk("irq", 32'h0, 32'(irq));
      rd(`FDHC_A_ISTAT, 32'h0000_0000, "irq_status");
      // Every rate through both rate registers, every precompensation code
      for (int r = 0; r < 4; r++) begin
         apb(1'b1, `FDHC_A_RATE, 32'(r));
         chk("data_rate", 32'(r), 32'(data_rate));
         chk("precomp_cycles", 32'(exp_pc(0, r)), 32'(precomp_cycles));
         for (int c = 0; c < 8; c++) begin
            apb(1'b1, `FDHC_A_DSR, 32'(c * 4 + 3 - r));
            chk("data_rate", 32'(3 - r), 32'(data_rate));
            chk("precomp_cycles", 32'(exp_pc(c, 3 - r)), 32'(precomp_cycles));
         end
         apb(1'b1, `FDHC_A_DSR, 32'(3 - r));
      end
      // DMA burst in both terminal count polarities
      for (int m = 0; m < 2; m++) begin
         alt <= m[0];
         apb(1'b1, `FDHC_A_CHIP, {29'h0, m[0], 2'h0});
         apb(1'b1, `FDHC_A_DOR, 32'h0000_0008);
         gap <= 2'($random(seed));
         core_drq <= 1'b1;
         tick(1);
         mon <= 1'b1;
         n = 0;
         while (tc_active !== 1'b1 && n < 60) begin
            tick(1);
            n++;
         end
         chk("tc_active", 32'h1, 32'(tc_active));
         chk("drq_pin", 32'h3, {30'h0, drq_out, drq_oe});
         core_drq <= 1'b0;
         tick(2);
         mon <= 1'b0;
         rd(`FDHC_A_ISTAT, 32'h0000_0001, "irq_status");
         apb(1'b1, `FDHC_A_ICLR, 32'h0000_0001);
      end
      complete_run();
   end
endmodule
